// File: frs_pkg.sv
// package: constants for result status and reset handling
package frs_pkg;
    // error status byte 1 bit positions
    localparam int ES1_END_TRACK   = 7;
    localparam int ES1_CRC         = 5;
    localparam int ES1_OVERRUN     = 4;
    localparam int ES1_NO_DATA     = 2;
    localparam int ES1_WRITE_BLOCK = 1;
    localparam int ES1_MARK_ABSENT = 0;
    // error status byte 2 bit positions
    localparam int ES2_CTRL_MARK   = 6;
    localparam int ES2_DATA_CRC    = 5;
    localparam int ES2_TRACK_MIS   = 4;
    localparam int ES2_BAD_TRACK   = 1;
    localparam int ES2_DMARK_ABS   = 0;
    // drive status bit positions
    localparam int DS_WPROT        = 6;
    localparam int DS_ONE_HI       = 5;
    localparam int DS_TRACK_ZERO_INPUT         = 4;
    localparam int DS_ONE_LO       = 3;
    localparam int DS_HEAD         = 2;
    // values
    localparam logic [7:0] BAD_TRACK_VALUE = 8'hFF;
    localparam logic [7:0] LAST_SECTOR     = 8'hFF;
    localparam logic [7:0] STATUS_RESET    = 8'h00;
    localparam logic [1:0] RESULT_BYTES    = 2'h3;
    localparam logic       POLL_RESET      = 1'b1;
    // result byte select
    localparam logic [1:0] SEL_ES1 = 2'h0;
    localparam logic [1:0] SEL_ES2 = 2'h1;
    localparam logic [1:0] SEL_DRV = 2'h2;
endpackage

// File: frs_sync_if.sv
// interface: synchronised drive cable levels
`timescale 1ns/1ps
interface frs_sync_if;
    logic [3:0] raw;
    logic [3:0] level;
    modport sync (input raw, output level);
    modport user (output raw, input level);
endinterface

// File: frs_sync.sv
// module: three stage synchroniser for drive cable inputs
`timescale 1ns/1ps
module frs_sync (
    // clock and reset
    input  wire logic clk_in,
    input  wire logic reset_in,
    // levels
    frs_sync_if.sync  port
);
    logic [3:0] s1_ff, s2_ff, s3_ff, lvl_ff;
    logic [3:0] nxt_lvl;

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_bit
            // level changes only once the last two stages agree
            always_comb begin
                nxt_lvl[g] = (s2_ff[g] == s3_ff[g]) ? s3_ff[g] : lvl_ff[g];
            end
        end
    endgenerate

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            s1_ff  <= 4'h0;
            s2_ff  <= 4'h0;
            s3_ff  <= 4'h0;
            lvl_ff <= 4'h0;
        end else begin
            s1_ff  <= port.raw;
            s2_ff  <= s1_ff;
            s3_ff  <= s2_ff;
            lvl_ff <= nxt_lvl;
        end
    end

    assign port.level = lvl_ff;
endmodule

// File: frs_core.sv
// module: result status bytes and reset control of the disk controller
`timescale 1ns/1ps
module frs_core (
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       reset_in,
    // software reset controls
    input  wire logic       dor_reset_write_in,
    input  wire logic       dor_reset_value_in,
    input  wire logic       rate_reset_write_in,
    // command sequencing
    input  wire logic       command_start_in,
    input  wire logic       result_start_in,
    input  wire logic       result_read_in,
    input  wire logic       configure_write_in,
    input  wire logic       configure_poll_off_in,
    input  wire logic       specify_write_in,
    input  wire logic [7:0] specify_value_in,
    // execution events
    input  wire logic       past_last_sector_in,
    input  wire logic       end_no_tc_in,
    input  wire logic       id_crc_error_in,
    input  wire logic       data_crc_error_in,
    input  wire logic       service_late_in,
    input  wire logic       sector_missed_in,
    input  wire logic       write_cmd_active_in,
    input  wire logic       id_mark_missing_in,
    input  wire logic       data_mark_missing_in,
    input  wire logic       control_mark_in,
    input  wire logic       id_track_valid_in,
    input  wire logic [7:0] id_track_in,
    input  wire logic [7:0] kept_track_in,
    // drive cable
    input  wire logic       write_protect_in,
    input  wire logic       track_zero_input_in,
    input  wire logic       head_select_in,
    input  wire logic [1:0] drive_select_in,
    // outputs
    output logic [7:0]      data_out,
    output logic            data_valid_out,
    output logic            core_reset_out,
    output logic            dor_reset_bit_out,
    output logic            power_down_exit_out,
    output logic            idle_out,
    output logic            polling_out,
    output logic [7:0]      specify_out,
    output logic            head_select_output_out,
    output logic [1:0]      drive_select_outputs_out
);
    typedef enum logic [1:0] {
        FRS_IDLE   = 2'b00,
        FRS_EXEC   = 2'b01,
        FRS_RESULT = 2'b10
    } frs_state_t;

    frs_sync_if cable();
    logic       write_prot, track_zero_input;
    assign cable.raw = {2'h0, track_zero_input_in, write_protect_in};
    assign write_prot = cable.level[0];
    assign track_zero_input       = cable.level[1];

    frs_sync u_sync (
        .clk_in   (clk_in),
        .reset_in (reset_in),
        .port     (cable.sync)
    );

    // reset control
    logic dor_rst_ff, rate_rst_ff, core_rst_ff, pd_exit_ff;
    logic nxt_dor_rst, nxt_rate_rst, nxt_core_rst;
    logic sw_reset;

    always_comb begin
        nxt_dor_rst  = dor_reset_write_in ? dor_reset_value_in : dor_rst_ff;
        nxt_rate_rst = rate_reset_write_in;
        sw_reset     = dor_rst_ff | rate_rst_ff;
        nxt_core_rst = sw_reset;
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            dor_rst_ff  <= 1'b1;
            rate_rst_ff <= 1'b0;
            core_rst_ff <= 1'b1;
            pd_exit_ff  <= 1'b1;
        end else begin
            dor_rst_ff  <= nxt_dor_rst;
            rate_rst_ff <= nxt_rate_rst;
            core_rst_ff <= nxt_core_rst;
            pd_exit_ff  <= sw_reset;
        end
    end

    // specify values survive software reset; pin reset keeps them as well
    logic [7:0] spec_ff, nxt_spec;
    always_comb begin
        nxt_spec = specify_write_in ? specify_value_in : spec_ff;
    end
    // no async reset on this flop; specify values are never cleared, only replaced by a specify write
    always_ff @(posedge clk_in) begin
        spec_ff <= nxt_spec;
    end

    // sequencing, flags and result read
    frs_state_t state_ff, nxt_state;
    logic [7:0] es1_ff, es2_ff, nxt_es1, nxt_es2;
    logic       poll_ff, nxt_poll;
    logic [1:0] sel_ff, nxt_sel;
    logic [7:0] data_ff, nxt_data;
    logic       dvalid_ff, nxt_dvalid;
    // idle kept in its own flop so the output needs no decode
    logic       idle_ff, nxt_idle;
    logic [7:0] drv_byte;
    logic       hd_ff;
    logic [1:0] ds_ff;
    logic       track_diff;

    always_comb begin
        track_diff = id_track_valid_in && (id_track_in != kept_track_in);
        drv_byte   = 8'h00;
        drv_byte[frs_pkg::DS_WPROT]  = write_prot;
        drv_byte[frs_pkg::DS_TRACK_ZERO_INPUT]   = track_zero_input;
        drv_byte[frs_pkg::DS_HEAD]   = hd_ff;
        drv_byte[1:0]                = ds_ff;
        drv_byte[frs_pkg::DS_ONE_HI] = 1'b1;
        drv_byte[frs_pkg::DS_ONE_LO] = 1'b1;
    end

    always_comb begin
        nxt_state  = state_ff;
        nxt_es1    = es1_ff;
        nxt_es2    = es2_ff;
        nxt_poll   = poll_ff;
        nxt_sel    = sel_ff;
        nxt_data   = data_ff;
        nxt_dvalid = 1'b0;
        if (configure_write_in) begin
            nxt_poll = ~configure_poll_off_in;
        end
        unique case (state_ff)
            FRS_IDLE: begin
                if (command_start_in) begin
                    nxt_es1   = frs_pkg::STATUS_RESET;
                    nxt_es2   = frs_pkg::STATUS_RESET;
                    nxt_state = FRS_EXEC;
                end
            end
            FRS_EXEC: begin
                // flags are sticky within one command
                if (past_last_sector_in || end_no_tc_in) nxt_es1[frs_pkg::ES1_END_TRACK] = 1'b1;
                if (id_crc_error_in || data_crc_error_in) nxt_es1[frs_pkg::ES1_CRC] = 1'b1;
                if (service_late_in) nxt_es1[frs_pkg::ES1_OVERRUN] = 1'b1;
                if (sector_missed_in) nxt_es1[frs_pkg::ES1_NO_DATA] = 1'b1;
                if (write_cmd_active_in && write_prot) nxt_es1[frs_pkg::ES1_WRITE_BLOCK] = 1'b1;
                if (id_mark_missing_in || data_mark_missing_in) nxt_es1[frs_pkg::ES1_MARK_ABSENT] = 1'b1;
                if (control_mark_in) nxt_es2[frs_pkg::ES2_CTRL_MARK] = 1'b1;
                if (data_crc_error_in) nxt_es2[frs_pkg::ES2_DATA_CRC] = 1'b1;
                if (track_diff) nxt_es2[frs_pkg::ES2_TRACK_MIS] = 1'b1;
                if (track_diff && id_track_in == frs_pkg::BAD_TRACK_VALUE) begin
                    nxt_es2[frs_pkg::ES2_BAD_TRACK] = 1'b1;
                end
                if (data_mark_missing_in) nxt_es2[frs_pkg::ES2_DMARK_ABS] = 1'b1;
                if (result_start_in) begin
                    nxt_sel    = frs_pkg::SEL_ES1;
                    nxt_data   = nxt_es1;
                    nxt_dvalid = 1'b1;
                    nxt_state  = FRS_RESULT;
                end
            end
            FRS_RESULT: begin
                // each host read steps to the next byte; the read on the drive status byte returns to idle
                if (result_read_in) begin
                    if (sel_ff == frs_pkg::SEL_DRV) begin
                        nxt_state = FRS_IDLE;
                    end else begin
                        nxt_sel    = sel_ff + 2'h1;
                        nxt_data   = (sel_ff == frs_pkg::SEL_ES1) ? es2_ff : drv_byte;
                        nxt_dvalid = 1'b1;
                    end
                end
            end
            default: nxt_state = FRS_IDLE;
        endcase
        nxt_idle   = (nxt_state == FRS_IDLE);
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            state_ff  <= FRS_IDLE;
            es1_ff    <= frs_pkg::STATUS_RESET;
            es2_ff    <= frs_pkg::STATUS_RESET;
            poll_ff   <= frs_pkg::POLL_RESET;
            sel_ff    <= frs_pkg::SEL_ES1;
            data_ff   <= 8'h00;
            dvalid_ff <= 1'b0;
            hd_ff     <= 1'b0;
            ds_ff     <= 2'h0;
            idle_ff   <= 1'b1;
        end else if (core_rst_ff) begin
            // software reset aborts everything and drops configure settings
            state_ff  <= FRS_IDLE;
            es1_ff    <= frs_pkg::STATUS_RESET;
            es2_ff    <= frs_pkg::STATUS_RESET;
            poll_ff   <= frs_pkg::POLL_RESET;
            sel_ff    <= frs_pkg::SEL_ES1;
            data_ff   <= 8'h00;
            dvalid_ff <= 1'b0;
            hd_ff     <= 1'b0;
            ds_ff     <= 2'h0;
            idle_ff   <= 1'b1;
        end else begin
            state_ff  <= nxt_state;
            es1_ff    <= nxt_es1;
            es2_ff    <= nxt_es2;
            poll_ff   <= nxt_poll;
            sel_ff    <= nxt_sel;
            data_ff   <= nxt_data;
            dvalid_ff <= nxt_dvalid;
            hd_ff     <= head_select_in;
            ds_ff     <= drive_select_in;
            idle_ff   <= nxt_idle;
        end
    end

    assign data_out                 = data_ff;
    assign data_valid_out           = dvalid_ff;
    assign core_reset_out           = core_rst_ff;
    assign dor_reset_bit_out        = dor_rst_ff;
    assign power_down_exit_out      = pd_exit_ff;
    assign idle_out                 = idle_ff;
    assign polling_out              = poll_ff;
    assign specify_out              = spec_ff;
    assign head_select_output_out   = hd_ff;
    assign drive_select_outputs_out = ds_ff;

    // assertions
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    reset_hold_a: assert property (dor_rst_ff |=> core_rst_ff) else $error("dor reset did not hold core");
    rate_clear_a: assert property (rate_rst_ff && !rate_reset_write_in |=> !rate_rst_ff)
        else $error("rate reset stuck");
    reset_idle_a: assert property (core_rst_ff |=> state_ff == FRS_IDLE) else $error("reset did not idle");
    flag_clear_a: assert property (state_ff == FRS_IDLE && command_start_in && !core_rst_ff
        |=> es1_ff == 8'h00 && es2_ff == 8'h00) else $error("flags not cleared");
    unused_zero_a: assert property (es1_ff[6] == 1'b0 && es1_ff[3] == 1'b0 && es2_ff[7] == 1'b0
        && es2_ff[3:2] == 2'h0) else $error("unused bit set");
    drive_ones_a: assert property (drv_byte[5] && drv_byte[3] && !drv_byte[7])
        else $error("fixed bits wrong");
    crc_flag_a: assert property (state_ff == FRS_EXEC && data_crc_error_in && !core_rst_ff
        && !result_start_in |=> es1_ff[5] && es2_ff[5]) else $error("crc flags not set");
    bad_track_a: assert property (es2_ff[1] |-> es2_ff[4]) else $error("bad track without mismatch");
    poll_reset_a: assert property (core_rst_ff |=> poll_ff) else $error("polling not restarted");
    result_seq_a: assert property (state_ff == FRS_RESULT && sel_ff == frs_pkg::SEL_ES1
        && result_read_in && !core_rst_ff |=> data_ff == es2_ff && dvalid_ff) else $error("second byte wrong");

    // each flag shows one cycle after its event
    end_track_a: assert property (state_ff == FRS_EXEC && !core_rst_ff
        && (past_last_sector_in || end_no_tc_in) |=> es1_ff[frs_pkg::ES1_END_TRACK])
        else $error("end of track flag not set");
    overrun_flag_a: assert property (state_ff == FRS_EXEC && !core_rst_ff
        && service_late_in |=> es1_ff[frs_pkg::ES1_OVERRUN])
        else $error("overrun flag not set");
    no_data_a: assert property (state_ff == FRS_EXEC && !core_rst_ff
        && sector_missed_in |=> es1_ff[frs_pkg::ES1_NO_DATA])
        else $error("no data flag not set");
    write_block_a: assert property (state_ff == FRS_EXEC && !core_rst_ff
        && write_cmd_active_in && write_prot |=> es1_ff[frs_pkg::ES1_WRITE_BLOCK])
        else $error("write blocked flag not set");
    mark_absent_a: assert property (state_ff == FRS_EXEC && !core_rst_ff
        && data_mark_missing_in |=> es1_ff[frs_pkg::ES1_MARK_ABSENT] && es2_ff[frs_pkg::ES2_DMARK_ABS])
        else $error("mark absent flags not set");
    ctrl_mark_a: assert property (state_ff == FRS_EXEC && !core_rst_ff
        && control_mark_in |=> es2_ff[frs_pkg::ES2_CTRL_MARK])
        else $error("control mark flag not set");
    track_mis_a: assert property (state_ff == FRS_EXEC && !core_rst_ff
        && track_diff |=> es2_ff[frs_pkg::ES2_TRACK_MIS])
        else $error("track mismatch flag not set");
    pd_exit_a: assert property (sw_reset |=> pd_exit_ff) else $error("power down not left");
    drive_pins_a: assert property (state_ff == FRS_RESULT && sel_ff == frs_pkg::SEL_ES2
        && result_read_in && !core_rst_ff
        |=> data_ff[frs_pkg::DS_WPROT] == $past(write_prot) && data_ff[frs_pkg::DS_TRACK_ZERO_INPUT] == $past(track_zero_input)
        && data_ff[frs_pkg::DS_HEAD] == $past(hd_ff) && data_ff[1:0] == $past(ds_ff))
        else $error("drive status byte wrong");

    cmd_cov_c: cover property (state_ff == FRS_IDLE ##1 state_ff == FRS_EXEC ##[1:20] state_ff == FRS_RESULT);
    sw_reset_c: cover property (state_ff == FRS_EXEC && core_rst_ff);
    bad_trk_c: cover property (es2_ff[1]);
    rate_rst_c: cover property (rate_rst_ff && !dor_rst_ff);
endmodule

// File: frs_drive_model.sv
// partner model: drive cable levels seen by the controller
`timescale 1ns/1ps
module frs_drive_model (
    // clock
    input  wire logic clk_in,
    // requested cable levels
    input  wire logic wp_req_in,
    input  wire logic track_zero_input_req_in,
    // cable pins
    output logic      write_protect_out,
    output logic      track_zero_out
);
    // pins move just after the edge, as a cable driven off the same clock would
    always_ff @(posedge clk_in) begin
        write_protect_out <= wp_req_in;
        track_zero_out    <= track_zero_input_req_in;
    end
endmodule

// File: test_floppy_result_status_reset.sv
// testbench: result status bytes and reset handling
`timescale 1ns/1ps
module test_floppy_result_status_reset;
    logic        clk_in   = 1'b0;
    logic        reset_in = 1'b1;
    logic        dor_wr   = 1'b0;
    logic        dor_val  = 1'b0;
    logic        rate_wr  = 1'b0;
    logic        cmd      = 1'b0;
    logic        res_go   = 1'b0;
    logic        res_rd   = 1'b0;
    logic        cfg_wr   = 1'b0;
    logic        poll_off = 1'b0;
    logic        spec_wr  = 1'b0;
    logic [7:0]  spec_val = 8'h00;
    logic [10:0] ev       = 11'h000;
    logic [7:0]  idt      = 8'h00;
    logic [7:0]  kt       = 8'h00;
    logic        wp_req   = 1'b0;
    logic        track_zero_input_req = 1'b0;
    logic        head     = 1'b0;
    logic [1:0]  sel      = 2'h0;
    logic        wp, track_zero_input, valid, core_rst, dor_bit, pd_exit, idle, polling, head_o;
    logic [7:0]  data, spec;
    logic [1:0]  sel_o;
    int          err_total   = 0;
    int          comparisons = 0;

    always #5 clk_in = ~clk_in;

    frs_drive_model u_frs_drive_model (.clk_in(clk_in), .wp_req_in(wp_req), .track_zero_input_req_in(track_zero_input_req),
        .write_protect_out(wp), .track_zero_out(track_zero_input));

    frs_core u_frs_core (.clk_in(clk_in), .reset_in(reset_in), .dor_reset_write_in(dor_wr),
        .dor_reset_value_in(dor_val), .rate_reset_write_in(rate_wr), .command_start_in(cmd),
        .result_start_in(res_go), .result_read_in(res_rd), .configure_write_in(cfg_wr),
        .configure_poll_off_in(poll_off), .specify_write_in(spec_wr), .specify_value_in(spec_val),
        .past_last_sector_in(ev[0]), .end_no_tc_in(ev[1]), .id_crc_error_in(ev[2]),
        .data_crc_error_in(ev[3]), .service_late_in(ev[4]), .sector_missed_in(ev[5]),
        .id_mark_missing_in(ev[6]), .data_mark_missing_in(ev[7]), .control_mark_in(ev[8]),
        .id_track_valid_in(ev[9]), .write_cmd_active_in(ev[10]), .id_track_in(idt), .kept_track_in(kt),
        .write_protect_in(wp), .track_zero_input_in(track_zero_input), .head_select_in(head), .drive_select_in(sel),
        .data_out(data), .data_valid_out(valid), .core_reset_out(core_rst), .dor_reset_bit_out(dor_bit),
        .power_down_exit_out(pd_exit), .idle_out(idle), .polling_out(polling), .specify_out(spec),
        .head_select_output_out(head_o), .drive_select_outputs_out(sel_o));

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t ns: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clk_in);
    endtask

    // expected first error byte from the events of one command
    function automatic logic [7:0] exp1(input logic [10:0] e, input logic w);
        return {e[0] | e[1], 1'b0, e[2] | e[3], e[4], 1'b0, e[5], e[10] & w, e[6] | e[7]};
    endfunction

    function automatic logic [7:0] exp2(input logic [10:0] e);
        logic mis;
        mis = e[9] && (idt !== kt);
        return {1'b0, e[8], e[3], mis, 2'b00, mis && (idt === 8'hFF), e[7]};
    endfunction

    task automatic get_byte(output logic [7:0] b);
        for (int i = 0; i < 8 && valid !== 1'b1; i++) tick(1);
        check({7'h00, valid}, 8'h01);
        b = data;
    endtask

    task automatic run_cmd(input logic [10:0] e, output logic [7:0] b1, b2, b3);
        cmd = 1'b1;
        tick(1);
        cmd = 1'b0;
        ev = e;
        tick(1);
        ev[9:0] = 10'h000;
        tick(2);
        ev[10] = 1'b0;
        res_go = 1'b1;
        tick(1);
        res_go = 1'b0;
        get_byte(b1);
        // read strobe held across the three bytes, one byte per edge
        res_rd = 1'b1;
        tick(1);
        get_byte(b2);
        tick(1);
        get_byte(b3);
        tick(1);
        res_rd = 1'b0;
        tick(2);
    endtask

    // host clears the output register reset bit and waits for the core to come out
    task automatic leave_reset();
        dor_wr = 1'b1;
        dor_val = 1'b0;
        tick(1);
        dor_wr = 1'b0;
        for (int i = 0; i < 6 && core_rst !== 1'b0; i++) tick(1);
        tick(1);
        check({5'h00, core_rst, dor_bit, idle}, 8'h01);
    endtask

    task automatic set_config();
        cfg_wr = 1'b1;
        poll_off = 1'b1;
        tick(1);
        cfg_wr = 1'b0;
        tick(2);
        check({7'h00, polling}, 8'h00);
    endtask

    task automatic t_events();
        logic [7:0] b1, b2, b3;
        logic [10:0] e;
        idt = 8'hFF;
        kt = 8'h03;
        // one event per command, last pass none: flags must not linger
        for (int i = 0; i < 12; i++) begin
            e = (i < 11) ? 11'h001 << i : 11'h000;
            wp_req = ~i[0];
            track_zero_input_req = i[1];
            head = i[2];
            sel = i[3:2];
            tick(6);
            run_cmd(e, b1, b2, b3);
            check(b1, exp1(e, wp_req));
            check(b2, exp2(e));
            check(b3, {1'b0, wp_req, 1'b1, track_zero_input_req, 1'b1, head, sel});
            check({5'h00, head_o, sel_o}, {5'h00, head, sel});
        end
    endtask

    task automatic t_track();
        logic [7:0] b1, b2, b3;
        for (int j = 0; j < 2; j++) begin
            idt = j ? 8'h03 : 8'h05;
            run_cmd(11'h200, b1, b2, b3);
            check(b2, exp2(11'h200));
        end
    endtask

    task automatic t_soft_reset();
        logic [7:0] b1, b2, b3;
        set_config();
        cmd = 1'b1;
        tick(1);
        cmd = 1'b0;
        ev = 11'h008;
        tick(1);
        ev = 11'h000;
        rate_wr = 1'b1;
        tick(1);
        rate_wr = 1'b0;
        // core follows the rate bit one edge later
        tick(1);
        check({6'h00, core_rst, pd_exit}, 8'h03);
        for (int i = 0; i < 6 && core_rst !== 1'b0; i++) tick(1);
        tick(1);
        check({4'h0, dor_bit, core_rst, idle, polling}, 8'h03);
        run_cmd(11'h000, b1, b2, b3);
        check(b1 | b2, 8'h00);
    endtask

    task automatic t_dor_wins();
        cmd = 1'b1;
        tick(1);
        cmd = 1'b0;
        dor_wr = 1'b1;
        dor_val = 1'b1;
        tick(1);
        dor_wr = 1'b0;
        rate_wr = 1'b1;
        tick(1);
        rate_wr = 1'b0;
        tick(4);
        check({5'h00, dor_bit, core_rst, pd_exit}, 8'h07);
        leave_reset();
    endtask

    task automatic t_pin_reset();
        spec_val = 8'hA5;
        spec_wr = 1'b1;
        tick(1);
        spec_wr = 1'b0;
        set_config();
        reset_in = 1'b1;
        tick(3);
        check({4'h0, dor_bit, core_rst, pd_exit, idle}, 8'h0F);
        reset_in = 1'b0;
        tick(5);
        check({5'h00, core_rst, idle, polling}, 8'h07);
        check(spec, 8'hA5);
        leave_reset();
    endtask

    initial begin
        tick(6);
        reset_in = 1'b0;
        tick(2);
        leave_reset();
        t_events();
        t_track();
        t_soft_reset();
        t_dor_wins();
        t_pin_reset();
        tally_and_finish();
    end

    // whole run is about 270 cycles; the 5000-cycle limit, over eighteen times that, means a hang
    initial begin
        #50000;
        err_total++;
        tally_and_finish();
    end
endmodule
